// file: core/ohc_pkg.sv
package ohc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int WD_TIMEOUT_US = 1000;
  localparam int WD_TIMEOUT_CYC = WD_TIMEOUT_US * CLK_MHZ;
  localparam int DET_SETTLE_US = 10;
  localparam int DET_SETTLE_CYC = DET_SETTLE_US * CLK_MHZ;
  localparam logic [7:0] DET_SETTLE_CNT = 8'(DET_SETTLE_CYC);
  localparam int POLL_US = 100;
  localparam int POLL_CYC = POLL_US * CLK_MHZ;
  localparam logic [10:0] POLL_LAST = 11'(POLL_CYC - 1);
  // ----------------------------------------------------------------
  // link register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] LA_CTRL = 4'h0;
  localparam logic [3:0] LA_FET = 4'h1;
  localparam logic [3:0] LA_MON = 4'h2;
  localparam logic [3:0] LA_CBAL = 4'h3;
  localparam logic [3:0] LA_DEMO = 4'h4;
  localparam logic [3:0] LA_STAT = 4'h5;
  localparam logic [3:0] LA_BALOUT = 4'h6;
  // ----------------------------------------------------------------
  // link register fields
  // ----------------------------------------------------------------
  localparam int C_SCAN = 0;
  localparam int C_FET = 1;
  localparam int C_CMON = 2;
  localparam int C_LMON = 3;
  localparam int C_BAL = 4;
  localparam int C_BALON = 5;
  localparam int C_PSD = 6;
  localparam int C_OWS = 7;
  localparam logic [7:0] C_OVR_MASK = 8'h1F;
  localparam logic [7:0] C_STORE_MASK = 8'h7F;
  localparam int M_CEN = 0;
  localparam int M_LEN = 1;
  localparam int M_CCLR = 2;
  localparam int D_FCHG = 0;
  localparam int D_FDSG = 1;
  localparam int D_FCOC = 2;
  localparam int S_CHP = 0;
  localparam int S_COC = 2;
  localparam int S_SD = 4;
  localparam int S_WAIT = 5;
  localparam int S_SCAN = 6;
  localparam int S_CBTMR = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] FET_RST = 2'h0;
  localparam logic [1:0] MON_RST = 2'h0;
  localparam logic [7:0] CBAL_RST = 8'h00;
  localparam logic [3:0] DEMO_RST = 4'h0;
  // ----------------------------------------------------------------
  // host bus map
  // ----------------------------------------------------------------
  localparam logic [7:0] HA_CMD = 8'h00;
  localparam logic [7:0] HA_STAT = 8'h04;
  localparam logic [7:0] HA_CFG = 8'h08;
  localparam int H_ADDR_LSB = 8;
  localparam int H_WR = 12;
  localparam int HC_POLL = 0;
  localparam int HC_ACLR = 1;
  localparam logic [1:0] CFG_RST = 2'h0;
  typedef enum logic [1:0] {WD_IDLE, WD_RUN, WD_WAIT} ohc_wd_t;
  typedef enum logic {H_IDLE, H_REQ} ohc_host_t;
  typedef enum logic [1:0] {SRC_SW, SRC_POLL, SRC_CLR} ohc_src_t;
endpackage

// file: core/ohc_link_if.sv
`timescale 1ns/10ps
interface ohc_link_if (
  input wire logic clk
);
  logic req;
  logic we;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport dev (input req, input we, input addr, input wdata,
               output ack, output rdata);
  modport host (output req, output we, output addr, output wdata,
                input ack, input rdata);
endinterface

// file: core/ohc_wdog.sv
`timescale 1ns/10ps
module ohc_wdog #(
  parameter int unsigned CYC = 20000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic kick,
  output logic expire
);
  localparam int W = $clog2(CYC + 1);
  localparam logic [W-1:0] LAST = W'(CYC - 1);
  logic [W-1:0] cnt_reg;

  // a kick in the same cycle as the last count wins, so no expiry
  // can race a transaction that is being served
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (!run || kick) begin
      cnt_reg <= '0;
    end else if (cnt_reg != LAST) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign expire = run && !kick && (cnt_reg == LAST);
endmodule

// file: core/ohc_device.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module ohc_device #(
  parameter int unsigned WD_CYC = ohc_pkg::WD_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  ohc_link_if.dev link,
  input wire logic [1:0] oc_event,
  input wire logic sc_event,
  input wire logic chg_current,
  input wire logic dsg_current,
  input wire logic [1:0] sense_pin,
  input wire logic other_error,
  input wire logic cb_during_charge,
  input wire logic [1:0] auto_fet,
  input wire logic [7:0] auto_balance,
  output logic scan_enable,
  output logic oc_monitor_enable,
  output logic [1:0] fet_drive,
  output logic [1:0] detect_enable,
  output logic pack_shutdown_output,
  output logic open_wire_start,
  output logic [7:0] balance_out,
  output logic balance_timer_enable,
  output logic wake_normal,
  output logic chg_dir,
  output logic dsg_dir,
  output logic shutdown_indicator
);
  import ohc_pkg::*;

  logic ack_reg;
  logic [7:0] rdata_reg;
  logic [7:0] ctrl_reg;
  logic [1:0] fet_reg;
  logic [1:0] mon_reg;
  logic [7:0] cbal_reg;
  logic [3:0] demo_reg;
  ohc_wd_t wd_reg;
  logic take;
  logic wr;
  logic expire;
  logic forced;
  logic no_current;
  logic any_ovr;
  logic [1:0] mon_ovr;
  logic [1:0] flag;
  logic [1:0] det_on;
  logic [1:0] sense_meta;
  logic [1:0] sense_sync;
  logic [7:0] stat;
  logic [7:0] rd_val;
  logic [7:0] bal_next;
  logic bal_ok;

  function automatic logic hit(input logic t, input logic [3:0] a,
                               input logic [3:0] b);
    return t && (a == b);
  endfunction

  assign take = link.req && !ack_reg;
  assign wr = take && link.we;
  assign forced = demo_reg[D_FCHG] | demo_reg[D_FDSG];
  assign no_current = !chg_current && !dsg_current;
  assign any_ovr = |(ctrl_reg & C_OVR_MASK);
  assign mon_ovr = ctrl_reg[C_LMON:C_CMON];
  assign link.ack = ack_reg;
  assign link.rdata = rdata_reg;

  // ----------------------------------------------------------------
  // link slave
  // ----------------------------------------------------------------
  assign stat = {balance_timer_enable, scan_enable, wd_reg == WD_WAIT,
                 shutdown_indicator, flag, sense_sync};

  always_comb begin
    case (link.addr)
      LA_CTRL: rd_val = ctrl_reg;
      LA_FET: rd_val = {6'h00, fet_reg};
      LA_MON: rd_val = {6'h00, mon_reg};
      LA_CBAL: rd_val = cbal_reg;
      LA_DEMO: rd_val = {4'h0, demo_reg};
      LA_STAT: rd_val = stat;
      LA_BALOUT: rd_val = balance_out;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg <= take;
      if (take) begin
        rdata_reg <= rd_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // host-written control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (hit(wr, link.addr, LA_CTRL)) begin
      ctrl_reg <= link.wdata & C_STORE_MASK;
    end else if (expire) begin
      ctrl_reg <= ctrl_reg & ~C_OVR_MASK;
    end
  end

  // writes are dropped unless the host owns the FETs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fet_reg <= FET_RST;
    end else if (hit(wr, link.addr, LA_FET) && ctrl_reg[C_FET]) begin
      fet_reg <= link.wdata[1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mon_reg <= MON_RST;
      cbal_reg <= CBAL_RST;
      demo_reg <= DEMO_RST;
    end else begin
      if (hit(wr, link.addr, LA_MON)) begin
        mon_reg <= link.wdata[M_LEN:M_CEN];
      end
      if (hit(wr, link.addr, LA_CBAL)) begin
        cbal_reg <= link.wdata;
      end
      if (hit(wr, link.addr, LA_DEMO)) begin
        demo_reg <= link.wdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // communication watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_reg <= WD_IDLE;
    end else begin
      case (wd_reg)
        WD_IDLE: begin
          if (any_ovr) begin
            wd_reg <= WD_RUN;
          end
        end
        WD_RUN: begin
          if (expire) begin
            wd_reg <= WD_WAIT;
          end else if (!any_ovr) begin
            wd_reg <= WD_IDLE;
          end
        end
        WD_WAIT: begin
          if (take) begin
            wd_reg <= WD_IDLE;
          end
        end
        default: wd_reg <= WD_IDLE;
      endcase
    end
  end

  // every served transaction restarts the count
  ohc_wdog #(
    .CYC(WD_CYC)
  ) u_wdog (
    .clk(clk),
    .rst(rst),
    .run(wd_reg == WD_RUN),
    .kick(take),
    .expire(expire)
  );

  // ----------------------------------------------------------------
  // overcurrent flags and recovery detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sense_meta <= 2'b00;
      sense_sync <= 2'b00;
    end else begin
      sense_meta <= sense_pin;
      sense_sync <= sense_meta;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_flt
      logic flag_reg;
      logic [7:0] cnt_reg;
      logic evt;
      logic done;
      logic clr;

      // real events only count when no direction is being forced
      assign evt = (oc_event[gi] | (sc_event & (gi == 1))) & !forced;
      assign done = cnt_reg == DET_SETTLE_CNT;
      assign det_on[gi] = flag_reg && !mon_ovr[gi] && no_current;
      // without the monitor override, a present load or charger holds the fault indefinitely
      assign clr = mon_ovr[gi]
                 ? hit(wr, link.addr, LA_MON) && link.wdata[M_CCLR + gi]
                 : det_on[gi] && done && !sense_sync[gi];

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cnt_reg <= 8'h00;
        end else if (!det_on[gi] || clr) begin
          cnt_reg <= 8'h00;
        end else if (!done) begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      end

      // the test level sits below the clear, so it re-fires next cycle
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          flag_reg <= 1'b0;
        end else if (evt) begin
          flag_reg <= 1'b1;
        end else if (clr) begin
          flag_reg <= 1'b0;
        end else if (demo_reg[D_FCOC + gi]) begin
          flag_reg <= 1'b1;
        end
      end

      assign flag[gi] = flag_reg;
    end
  endgenerate

  // ----------------------------------------------------------------
  // balancing
  // ----------------------------------------------------------------
  always_comb begin
    bal_ok = !other_error && !(|flag)
           && !(cb_during_charge && !(chg_current || demo_reg[D_FCHG]));
    if (!bal_ok) begin
      bal_next = 8'h00;
    end else if (ctrl_reg[C_BAL]) begin
      bal_next = ctrl_reg[C_BALON] ? cbal_reg : 8'h00;
    end else if (wd_reg == WD_WAIT || ctrl_reg[C_SCAN]) begin
      bal_next = 8'h00;
    end else begin
      bal_next = auto_balance;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_enable <= 1'b0;
      oc_monitor_enable <= 1'b0;
      fet_drive <= 2'b00;
      detect_enable <= 2'b00;
      pack_shutdown_output <= 1'b0;
      open_wire_start <= 1'b0;
      balance_out <= 8'h00;
      balance_timer_enable <= 1'b0;
      wake_normal <= 1'b0;
      chg_dir <= 1'b0;
      dsg_dir <= 1'b0;
      shutdown_indicator <= 1'b0;
    end else begin
      scan_enable <= !ctrl_reg[C_SCAN] && wd_reg != WD_WAIT;
      oc_monitor_enable <= !forced;
      fet_drive <= ctrl_reg[C_FET] ? fet_reg
                                   : auto_fet & ~flag;
      detect_enable <= (mon_ovr & mon_reg) | (~mon_ovr & det_on);
      pack_shutdown_output <= ctrl_reg[C_PSD];
      open_wire_start <= hit(wr, link.addr, LA_CTRL)
                         && link.wdata[C_OWS];
      balance_out <= bal_next;
      balance_timer_enable <= !ctrl_reg[C_BAL];
      wake_normal <= demo_reg[D_FCHG];
      chg_dir <= chg_current || demo_reg[D_FCHG];
      dsg_dir <= dsg_current || demo_reg[D_FDSG];
      shutdown_indicator <= |flag;
    end
  end
endmodule

// file: core/ohc_host.sv
`timescale 1ns/10ps
module ohc_host (
  input wire logic clk,
  input wire logic rst,
  ohc_link_if.host link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  import ohc_pkg::*;

  ohc_host_t st_reg;
  ohc_src_t src_reg;
  logic aph;
  logic dph_wr;
  logic [7:0] dph_addr;
  logic [31:0] rd_val;
  logic [1:0] cfg_reg;
  logic sw_pend;
  logic [12:0] sw_cmd;
  logic done_reg;
  logic [7:0] last_rd;
  logic [1:0] ovr_mirror;
  logic [1:0] en_mirror;
  logic [1:0] clr_pend;
  logic poll_pend;
  logic [10:0] poll_cnt;
  logic launch;
  logic acked;
  ohc_src_t pick;
  logic [3:0] l_addr;
  logic [7:0] l_data;
  logic l_we;

  // ----------------------------------------------------------------
  // bus slave, zero wait states
  // ----------------------------------------------------------------
  assign aph = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    case (haddr[7:0])
      HA_STAT: rd_val = {22'h0, done_reg, sw_pend, last_rd};
      HA_CFG: rd_val = {30'h0, cfg_reg};
      default: rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dph_wr <= 1'b0;
      dph_addr <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      dph_wr <= aph && hwrite;
      if (aph) begin
        dph_addr <= haddr[7:0];
      end
      if (aph && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= CFG_RST;
    end else if (dph_wr && dph_addr == HA_CFG) begin
      cfg_reg <= hwdata[1:0];
    end
  end

  // a command written while one is still pending is dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_pend <= 1'b0;
      sw_cmd <= 13'h0;
      done_reg <= 1'b0;
      last_rd <= 8'h00;
    end else if (acked && src_reg == SRC_SW) begin
      sw_pend <= 1'b0;
      done_reg <= 1'b1;
      last_rd <= link.rdata;
    end else if (dph_wr && dph_addr == HA_CMD && !sw_pend) begin
      sw_pend <= 1'b1;
      sw_cmd <= hwdata[12:0];
      done_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // link master
  // ----------------------------------------------------------------
  always_comb begin
    launch = st_reg == H_IDLE;
    pick = SRC_POLL;
    l_we = 1'b0;
    l_addr = LA_STAT;
    l_data = 8'h00;
    if (sw_pend) begin
      pick = SRC_SW;
      l_we = sw_cmd[H_WR];
      l_addr = sw_cmd[H_ADDR_LSB +: 4];
      l_data = sw_cmd[7:0];
    end else if (|clr_pend && cfg_reg[HC_ACLR]) begin
      pick = SRC_CLR;
      l_we = 1'b1;
      l_addr = LA_MON;
      l_data = {4'h0, clr_pend, en_mirror};
    end else if (!poll_pend) begin
      launch = 1'b0;
    end
  end

  assign acked = st_reg == H_REQ && link.ack;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= H_IDLE;
      src_reg <= SRC_SW;
      link.req <= 1'b0;
      link.we <= 1'b0;
      link.addr <= 4'h0;
      link.wdata <= 8'h00;
    end else if (acked) begin
      st_reg <= H_IDLE;
      link.req <= 1'b0;
    end else if (launch) begin
      st_reg <= H_REQ;
      src_reg <= pick;
      link.req <= 1'b1;
      link.we <= l_we;
      link.addr <= l_addr;
      link.wdata <= l_data;
    end
  end

  // ----------------------------------------------------------------
  // polling, error recovery, keep-alive
  // ----------------------------------------------------------------
  // periodic status reads also keep the device watchdog fed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      poll_cnt <= 11'h0;
      poll_pend <= 1'b0;
    end else begin
      if (!cfg_reg[HC_POLL] || poll_cnt == POLL_LAST) begin
        poll_cnt <= 11'h0;
      end else begin
        poll_cnt <= poll_cnt + 11'h1;
      end
      if (acked && src_reg == SRC_POLL) begin
        poll_pend <= 1'b0;
      end else if (cfg_reg[HC_POLL] && poll_cnt == POLL_LAST) begin
        poll_pend <= 1'b1;
      end
    end
  end

  // a device in watchdog wait has dropped every override
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovr_mirror <= 2'b00;
      en_mirror <= 2'b00;
      clr_pend <= 2'b00;
    end else if (launch && l_we && l_addr == LA_CTRL) begin
      ovr_mirror <= l_data[C_LMON:C_CMON];
    end else if (launch && l_we && l_addr == LA_MON) begin
      en_mirror <= l_data[1:0];
      clr_pend <= 2'b00;
    end else if (acked && src_reg == SRC_POLL) begin
      if (link.rdata[S_WAIT]) begin
        ovr_mirror <= 2'b00;
      end
      clr_pend <= ovr_mirror & link.rdata[S_COC+1:S_COC]
                & ~link.rdata[S_CHP+1:S_CHP];
    end
  end
endmodule

// file: tb/ohc_link_sva.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// link and pin checks
// ----------------------------------------------------------------
module ohc_link_sva
  import ohc_pkg::*;
(
  input logic clk,
  input logic rst,
  input logic req,
  input logic we,
  input logic [3:0] addr,
  input logic [7:0] wdata,
  input logic ack,
  input logic [7:0] rdata,
  input logic scan_enable,
  input logic oc_monitor_enable,
  input logic [1:0] fet_drive,
  input logic pack_shutdown_output,
  input logic open_wire_start,
  input logic balance_timer_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic fet_ovr_reg;
  wire tk = req & ~ack;
  wire tk_ctrl = tk & we & (addr == LA_CTRL);
  // a watchdog drop of the bit is not seen here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fet_ovr_reg <= 1'b0;
    end else if (tk_ctrl) begin
      fet_ovr_reg <= wdata[C_FET];
    end
  end
  ack_after_take_a: assert property (tk |=> ack)
    else $error("no ack after request");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  rdata_hold_a: assert property (!tk |=> $stable(rdata))
    else $error("read data moved without request");
  scan_halt_a:
    assert property (tk_ctrl && wdata[C_SCAN] |-> ##2 !scan_enable)
    else $error("scan kept running under override");
  oc_kept_a:
    assert property ($fell(scan_enable) |-> oc_monitor_enable)
    else $error("overcurrent watch lost with scan");
  fet_follow_a:
    assert property (tk && we && addr == LA_FET && fet_ovr_reg
      |-> ##2 fet_drive == $past(wdata[1:0], 2))
    else $error("fets ignore host bits");
  psd_pin_a:
    assert property (tk_ctrl
      |-> ##2 pack_shutdown_output == $past(wdata[C_PSD], 2))
    else $error("shutdown pin not following bit");
  ows_pulse_a:
    assert property (tk_ctrl && wdata[C_OWS]
      |-> ##1 open_wire_start ##1 !open_wire_start)
    else $error("open wire start not one pulse");
  bal_timer_off_a:
    assert property (tk_ctrl && wdata[C_BAL]
      |-> ##2 !balance_timer_enable)
    else $error("balance timers on under host control");
endmodule

// file: tb/tb_top.sv
`timescale 1ns/10ps
`define CK(n, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("FAIL %s exp %0h got %0h", n, e, g); \
    end \
  end
module tb_top;
  import ohc_pkg::*;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, sc_event;
  logic chg_current, dsg_current, other_error, cb_during_charge;
  logic scan_enable, oc_monitor_enable, pack_shutdown_output;
  logic open_wire_start, balance_timer_enable, wake_normal;
  logic chg_dir, dsg_dir, shutdown_indicator;
  logic [1:0] htrans, oc_event, sense_pin, auto_fet, fet_drive;
  logic [1:0] detect_enable;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, s;
  logic [7:0] auto_balance, balance_out, q;
  int fail_count, total_checks, k;
  ohc_link_if i_link (.clk(clk));
  ohc_host i_ohc_host (.clk, .rst, .link(i_link), .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata);
  ohc_device #(.WD_CYC(100)) i_ohc_device (.clk, .rst, .link(i_link),
    .oc_event, .sc_event, .chg_current, .dsg_current, .sense_pin,
    .other_error, .cb_during_charge, .auto_fet, .auto_balance,
    .scan_enable, .oc_monitor_enable, .fet_drive, .detect_enable,
    .pack_shutdown_output, .open_wire_start, .balance_out,
    .balance_timer_enable, .wake_normal, .chg_dir, .dsg_dir,
    .shutdown_indicator);
  ohc_link_sva i_sva (.clk(clk), .rst(rst), .req(i_link.req),
    .we(i_link.we), .addr(i_link.addr), .wdata(i_link.wdata),
    .ack(i_link.ack), .rdata(i_link.rdata), .scan_enable,
    .oc_monitor_enable, .fet_drive, .pack_shutdown_output,
    .open_wire_start, .balance_timer_enable);
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      print_verdict;
    end
  endtask
  task hw(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    s = hrdata;
  endtask
  // link transfer through the host command register
  task lk(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    hw(1'b1, HA_CMD, {19'h0, w, a, d});
    n = 0;
    do begin
      hw(1'b0, HA_STAT, 32'h0);
      n++;
    end while (s[9] !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      print_verdict;
    end
    q = s[7:0];
    cyc(2);
  endtask
  task pulse(input logic [1:0] oc, input logic sc);
    oc_event <= oc;
    sc_event <= sc;
    cyc(2);
    oc_event <= 2'h0;
    sc_event <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    cyc(20000);
    fail_count++;
    print_verdict;
  end
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    {oc_event, sc_event, chg_current, dsg_current, sense_pin} = '0;
    {other_error, cb_during_charge} = '0;
    auto_fet = 2'h3;
    auto_balance = 8'h3C;
    fail_count = 0;
    total_checks = 0;
    cyc(5);
    rst <= 1'b0;
    cyc(3);
    `CK("scan", 1'b1, scan_enable)
    `CK("hresp", 1'b0, hresp)
    hw(1'b0, 8'h0C, 32'h0);
    `CK("unmapped", 32'h0, s)
    hw(1'b1, HA_CFG, 32'h2);
    hw(1'b0, HA_CFG, 32'h0);
    `CK("cfg", 32'h2, s)
    hw(1'b1, HA_CFG, 32'h0);
    lk(1'b0, 4'h7, 8'h0);
    `CK("linkgap", 8'h0, q)
    lk(1'b1, LA_CTRL, 8'h40);
    `CK("psd", 1'b1, pack_shutdown_output)
    lk(1'b1, LA_CTRL, 8'h80);
    lk(1'b0, LA_CTRL, 8'h0);
    `CK("ctrl", CTRL_RST, q)
    lk(1'b1, LA_FET, 8'h0);
    `CK("fet", 2'h3, fet_drive)
    lk(1'b1, LA_CTRL, 8'h02);
    lk(1'b1, LA_FET, 8'h01);
    `CK("fet", 2'h1, fet_drive)
    lk(1'b1, LA_CTRL, 8'h01);
    `CK("scan", 1'b0, scan_enable)
    `CK("ocmon", 1'b1, oc_monitor_enable)
    pulse(2'h1, 1'b0);
    lk(1'b0, LA_STAT, 8'h0);
    `CK("coc", 1'b1, q[S_COC])
    lk(1'b1, LA_CTRL, 8'h0);
    `CK("det", 2'h1, detect_enable)
    cyc(250);
    lk(1'b0, LA_STAT, 8'h0);
    `CK("coc", 1'b0, q[S_COC])
    sense_pin <= 2'h2;
    pulse(2'h0, 1'b1);
    cyc(250);
    lk(1'b0, LA_STAT, 8'h0);
    `CK("doc", 1'b1, q[3])
    `CK("sd", 1'b1, shutdown_indicator)
    sense_pin <= 2'h0;
    cyc(250);
    lk(1'b0, LA_STAT, 8'h0);
    `CK("doc", 1'b0, q[3])
    lk(1'b1, LA_DEMO, 8'h01);
    `CK("chgdir", 1'b1, chg_dir)
    `CK("wake", 1'b1, wake_normal)
    `CK("ocmon", 1'b0, oc_monitor_enable)
    pulse(2'h1, 1'b0);
    lk(1'b0, LA_STAT, 8'h0);
    `CK("coc", 1'b0, q[S_COC])
    lk(1'b1, LA_DEMO, 8'h02);
    `CK("dsgdir", 1'b1, dsg_dir)
    pulse(2'h0, 1'b1);
    lk(1'b0, LA_STAT, 8'h0);
    `CK("doc", 1'b0, q[3])
    lk(1'b1, LA_DEMO, 8'h04);
    lk(1'b0, LA_STAT, 8'h0);
    `CK("coc", 1'b1, q[S_COC])
    // the held test bit must set the flag again after each clear
    cyc(250);
    lk(1'b0, LA_STAT, 8'h0);
    `CK("coc", 1'b1, q[S_COC])
    lk(1'b1, LA_DEMO, 8'h0);
    cyc(250);
    lk(1'b0, LA_STAT, 8'h0);
    `CK("coc", 1'b0, q[S_COC])
    lk(1'b1, LA_CTRL, 8'h0C);
    lk(1'b1, LA_MON, 8'h03);
    `CK("det", 2'h3, detect_enable)
    pulse(2'h1, 1'b0);
    lk(1'b0, LA_STAT, 8'h0);
    `CK("coc", 1'b1, q[S_COC])
    lk(1'b1, LA_MON, 8'h07);
    lk(1'b0, LA_STAT, 8'h0);
    `CK("coc", 1'b0, q[S_COC])
    pulse(2'h2, 1'b0);
    lk(1'b1, LA_MON, 8'h0B);
    lk(1'b0, LA_STAT, 8'h0);
    `CK("doc", 1'b0, q[3])
    // host poll plus auto clear; software reads keep the watchdog fed
    hw(1'b1, HA_CFG, 32'h3);
    pulse(2'h1, 1'b0);
    k = 0;
    do begin
      lk(1'b0, LA_STAT, 8'h0);
      k++;
    end while (q[S_COC] !== 1'b0 && k < 300);
    `CK("autoclr", 1'b0, q[S_COC])
    hw(1'b1, HA_CFG, 32'h0);
    lk(1'b1, LA_CTRL, 8'h0);
    lk(1'b1, LA_CBAL, 8'hA5);
    lk(1'b1, LA_CTRL, 8'h30);
    `CK("bal", 8'hA5, balance_out)
    `CK("baltmr", 1'b0, balance_timer_enable)
    other_error <= 1'b1;
    cyc(3);
    `CK("bal", 8'h0, balance_out)
    other_error <= 1'b0;
    cb_during_charge <= 1'b1;
    cyc(3);
    `CK("bal", 8'h0, balance_out)
    chg_current <= 1'b1;
    cyc(3);
    `CK("bal", 8'hA5, balance_out)
    {cb_during_charge, chg_current} <= 2'h0;
    lk(1'b1, LA_CTRL, 8'h11);
    repeat (15) lk(1'b0, LA_STAT, 8'h0);
    lk(1'b0, LA_CTRL, 8'h0);
    `CK("ovr", 5'h11, q[4:0])
    cyc(150);
    `CK("scan", 1'b0, scan_enable)
    lk(1'b0, LA_STAT, 8'h0);
    `CK("wait", 1'b1, q[S_WAIT])
    lk(1'b0, LA_CTRL, 8'h0);
    `CK("ovr", 5'h0, q[4:0])
    `CK("scan", 1'b1, scan_enable)
    `CK("autobal", 8'h3C, balance_out)
    print_verdict;
  end
endmodule
